// ---- core/rtcp_pkg.sv ----
// Shared constants, types and helpers of the three-wire clock host port.
package rtcp_pkg;

  // ****************************************************************
  // Serial frame layout
  // ****************************************************************
  localparam int          ADDR_W     = 4;
  localparam int          DATA_W     = 8;
  localparam int          WORD_W     = 12;
  localparam logic [2:0]  CMD_CODE   = 3'h3;
  localparam logic [3:0]  LAST_BIT   = 4'h7;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam int          NUM_REGS   = 11;
  localparam logic [3:0]  REG_STAT1  = 4'h0;
  localparam logic [3:0]  REG_STAT2  = 4'h1;
  localparam logic [3:0]  REG_YEAR   = 4'h2;
  localparam logic [3:0]  REG_MONTH  = 4'h3;
  localparam logic [3:0]  REG_DAY    = 4'h4;
  localparam logic [3:0]  REG_HOUR   = 4'h5;
  localparam logic [3:0]  REG_MIN    = 4'h6;
  localparam logic [3:0]  REG_SEC    = 4'h7;
  localparam logic [3:0]  REG_ALM1   = 4'h8;
  localparam logic [3:0]  REG_ALM2   = 4'h9;
  localparam logic [3:0]  REG_FREQ   = 4'hA;
  localparam int          ST1_POWER  = 0;
  localparam int          ST1_LOWV   = 1;
  localparam logic [7:0]  ST1_MASK   = 8'h03;
  localparam logic [NUM_REGS*8-1:0] RST_REGS = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                                8'h01, 8'h01, 8'h00, 8'h07, 8'h01};

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          DEF_CLK_HZ    = 1000000000 / CLK_PERIOD_NS;
  localparam int          HALF_STEP     = 65536;
  localparam int          DEF_HALF_SEC  = 65536;
  localparam logic [1:0]  BUF_FULL      = 2'h2;

  typedef logic [NUM_REGS-1:0][7:0] rtcp_regs_t;

  typedef enum logic [2:0] {
    SRC_ALM1 = 3'h0,
    SRC_ALM2 = 3'h1,
    SRC_FREQ = 3'h2,
    SRC_PER1 = 3'h3,
    SRC_PER2 = 3'h4,
    SRC_32K  = 3'h5
  } rtcp_src_t;

  typedef enum logic [1:0] {
    LK_CMD  = 2'h0,
    LK_WR   = 2'h1,
    LK_RD   = 2'h2,
    LK_IDLE = 2'h3
  } rtcp_phase_t;

  // Years 00 to 99 stand for 2000 to 2099, so every fourth year is a leap year.
  function automatic logic [7:0] days_in_month(input logic [7:0] month, input logic [7:0] year);
    unique case (month)
      8'h02:                      days_in_month = (year[1:0] == 2'h0) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: days_in_month = 8'h1E;
      default:                    days_in_month = 8'h1F;
    endcase
  endfunction : days_in_month

  function automatic logic [7:0] rd_reg(input rtcp_regs_t regs, input logic [3:0] addr);
    rd_reg = (addr < 4'(NUM_REGS)) ? regs[addr] : 8'h00;
  endfunction : rd_reg

endpackage : rtcp_pkg

// ---- core/rtcp_stream_if.sv ----
// Valid and ready carrier for register write words.
`timescale 1ns/1ps
`default_nettype none
interface rtcp_stream_if;
  import rtcp_pkg::*;
  logic              valid;
  logic              ready;
  logic [WORD_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rtcp_stream_if
`default_nettype wire

// ---- core/rtcp_buf2.sv ----
// Two-entry buffer for register write words.
`timescale 1ns/1ps
`default_nettype none
module rtcp_buf2 (
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  rtcp_stream_if.snk  in_if,
  rtcp_stream_if.src  out_if
);
  import rtcp_pkg::*;

  typedef struct packed {
    logic [1:0][WORD_W-1:0] mem;
    logic                   wp;
    logic                   rp;
    logic [1:0]             cnt;
  } rtcp_buf_t;

  rtcp_buf_t q;
  rtcp_buf_t d;
  logic      push;
  logic      pop;

  assign in_if.ready  = (q.cnt != BUF_FULL);
  assign out_if.valid = (q.cnt != 2'h0);
  assign out_if.data  = q.mem[q.rp];
  assign push         = in_if.valid & in_if.ready;
  assign pop          = out_if.valid & out_if.ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_if.data;
      d.wp        = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    if (push && !pop) begin
      d.cnt = 2'(q.cnt + 2'h1);
    end else if (pop && !push) begin
      d.cnt = 2'(q.cnt - 2'h1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  buf_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R04
    (q.cnt == BUF_FULL && !pop) |=> (q.cnt == BUF_FULL) && !in_if.ready)
    else $error("buffer lost its full state");
  buf_order_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R04
    (push && q.cnt == 2'h0) |=> out_if.valid && (out_if.data == $past(in_if.data)))
    else $error("buffered word lost or changed");
  buf_full_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) q.cnt == BUF_FULL);

endmodule : rtcp_buf2
`default_nettype wire

// ---- core/rtcp_top.sv ----
// Three-wire host port, calendar and interrupt output of the real-time clock.
//
// Function
// R01 - Transfers happen only while chip select is high; host idles it low or open.
// R02 - A floating chip select counts as deasserted, held low by pull-down.
// R03 - With chip select low, serial clock edges are ignored and nothing advances.
// R04 - With chip select high, data shifts in and out timed by serial clock.
// R05 - With chip select low, the data pin is released and nothing is sent.
// R06 - On chip select rising, the data pin is input and a command comes first.
// R07 - Status register two picks one of six sources for the interrupt pin.
// R08 - The interrupt pin is open drain: pulled low or released, never driven high.
// R09 - Calendar rolls over automatically with leap years, correct up to 2099.
// R10 - A readable flag is set at power-on and on low supply voltage.
// R11 - Host keeps serial clock idle while it changes chip select.
`timescale 1ns/1ps
`default_nettype none
module rtcp_top #(
  parameter int unsigned CLK_HZ   = rtcp_pkg::DEF_CLK_HZ,
  parameter int unsigned HALF_SEC = rtcp_pkg::DEF_HALF_SEC
) (
  input  wire logic I_CLK,
  input  wire logic I_RSTN,
  input  wire logic I_SCK,
  input  wire logic I_CS,
  input  wire logic I_SIO_I,
  input  wire logic I_LOW_VDD,
  output logic      O_SIO_O,
  output logic      O_SIO_OE,
  output logic      O_INT_N_O,
  output logic      O_INT_N_OE
);
  import rtcp_pkg::*;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef struct packed {
    logic              cs_s1;
    logic              cs_s2;
    logic              lv_s1;
    logic              lv_s2;
    logic              tg_s1;
    logic              tg_s2;
    logic              tg_s3;
    logic              pend;
    logic [WORD_W-1:0] pend_word;
    logic [31:0]       acc;
    logic [16:0]       half_cnt;
    logic              clk32;
    logic [7:0]        fdiv;
    logic              fout;
    logic              int_oe;
    rtcp_regs_t        regs;
    rtcp_regs_t        snap;
  } rtcp_core_t;

  typedef struct packed {
    rtcp_phase_t       phase;
    logic [3:0]        cnt;
    logic [7:0]        sh;
    logic [3:0]        addr;
    logic [7:0]        out_sh;
    logic              drv_low;
  } rtcp_link_t;

  typedef struct packed {
    logic              tgl;
    logic [WORD_W-1:0] word;
  } rtcp_wpost_t;

  localparam rtcp_core_t CORE_RST = '{regs: RST_REGS, snap: RST_REGS, default: '0};

  rtcp_core_t  core_q;
  rtcp_core_t  core_d;
  rtcp_link_t  lk_q;
  rtcp_link_t  lk_d;
  rtcp_wpost_t wp_q;
  rtcp_wpost_t wp_d;
  logic        lk_rst_n;
  logic [32:0] acc_sum;
  logic        half_ev;
  logic        tick;
  logic        pop_fire;
  logic [7:0]  cmd;
  logic [7:0]  rd_val;
  rtcp_src_t   src;
  logic        int_act;

  rtcp_stream_if push_if ();
  rtcp_stream_if pop_if ();

  rtcp_buf2 u_buf (
    .i_clk   (I_CLK),
    .i_rst_n (I_RSTN),
    .in_if   (push_if),
    .out_if  (pop_if)
  );

  // ****************************************************************
  // Link side, clocked by the serial clock
  // ****************************************************************
  // The pull-down makes an open chip select read low, which holds the frame
  // logic in reset; every frame therefore starts with a command phase.
  assign lk_rst_n = I_RSTN & I_CS; // R01 R02 R06
  assign cmd      = {lk_q.sh[6:0], I_SIO_I};
  assign rd_val   = rd_reg(core_q.snap, cmd[4:1]);

  always_comb begin
    lk_d = lk_q;
    wp_d = wp_q;
    unique case (lk_q.phase)
      LK_CMD: begin
        lk_d.sh  = cmd; // R04
        lk_d.cnt = 4'(lk_q.cnt + 4'h1);
        if (lk_q.cnt == LAST_BIT) begin
          lk_d.cnt  = 4'h0;
          lk_d.addr = cmd[4:1];
          if (cmd[7:5] != CMD_CODE) begin
            lk_d.phase = LK_IDLE;
          end else if (cmd[0]) begin
            lk_d.phase   = LK_RD;
            lk_d.drv_low = ~rd_val[7];
            lk_d.out_sh  = {rd_val[6:0], 1'b0};
          end else begin
            lk_d.phase = LK_WR;
          end
        end
      end
      LK_WR: begin
        lk_d.sh  = cmd; // R04
        lk_d.cnt = 4'(lk_q.cnt + 4'h1);
        if (lk_q.cnt == LAST_BIT) begin
          lk_d.phase = LK_IDLE;
          wp_d.word  = {lk_q.addr, cmd};
          wp_d.tgl   = ~wp_q.tgl;
        end
      end
      LK_RD: begin
        if (lk_q.cnt == LAST_BIT) begin
          lk_d.phase   = LK_IDLE;
          lk_d.drv_low = 1'b0;
        end else begin
          lk_d.drv_low = ~lk_q.out_sh[7]; // R04
          lk_d.out_sh  = {lk_q.out_sh[6:0], 1'b0};
          lk_d.cnt     = 4'(lk_q.cnt + 4'h1);
        end
      end
      LK_IDLE: begin
        lk_d.drv_low = 1'b0;
      end
    endcase
  end

  // Frame state clears the moment chip select falls, releasing the data pin.
  always_ff @(posedge I_SCK or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_q <= '0; // R03 R05
    end else begin
      lk_q <= lk_d;
    end
  end

  // The finished write word outlives the frame so the core can fetch it.
  always_ff @(posedge I_SCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wp_q <= '0;
    end else begin
      wp_q <= wp_d;
    end
  end

  assign O_SIO_O  = 1'b0;
  assign O_SIO_OE = lk_q.drv_low; // R05

  // ****************************************************************
  // Core side, timebase and calendar
  // ****************************************************************
  assign acc_sum        = {1'b0, core_q.acc} + 33'(HALF_STEP);
  assign half_ev        = (acc_sum >= 33'(CLK_HZ));
  assign tick           = half_ev && (core_q.half_cnt == 17'(HALF_SEC - 1));
  assign pop_if.ready   = ~tick;
  assign pop_fire       = pop_if.valid & pop_if.ready;
  assign push_if.valid  = core_q.pend;
  assign push_if.data   = core_q.pend_word;
  assign src            = rtcp_src_t'(core_q.regs[REG_STAT2][2:0]);

  always_comb begin
    unique case (src) // R07
      SRC_ALM1: int_act = (core_q.regs[REG_MIN] == core_q.regs[REG_ALM1]);
      SRC_ALM2: int_act = (core_q.regs[REG_HOUR] == core_q.regs[REG_ALM2]);
      SRC_FREQ: int_act = core_q.fout;
      SRC_PER1: int_act = (core_q.regs[REG_SEC] < 8'h1E);
      SRC_PER2: int_act = (core_q.regs[REG_SEC] == 8'h00);
      SRC_32K:  int_act = core_q.clk32;
      default:  int_act = 1'b0;
    endcase
  end

  always_comb begin
    core_d       = core_q;
    core_d.cs_s1 = I_CS;
    core_d.cs_s2 = core_q.cs_s1;
    core_d.lv_s1 = I_LOW_VDD;
    core_d.lv_s2 = core_q.lv_s1;
    core_d.tg_s1 = wp_q.tgl;
    core_d.tg_s2 = core_q.tg_s1;
    core_d.tg_s3 = core_q.tg_s2;
    core_d.int_oe = int_act; // R08
    if (core_q.pend && push_if.ready) begin
      core_d.pend = 1'b0;
    end
    // The word was loaded into the link flops on the same serial clock edge as the toggle and has held since.
    if (core_q.tg_s2 != core_q.tg_s3) begin
      core_d.pend      = 1'b1;
      core_d.pend_word = wp_q.word;
    end
    core_d.acc = half_ev ? 32'(acc_sum - 33'(CLK_HZ)) : acc_sum[31:0];
    if (half_ev) begin
      core_d.clk32    = ~core_q.clk32;
      core_d.half_cnt = tick ? 17'h00000 : 17'(core_q.half_cnt + 17'h00001);
      if (core_q.fdiv == core_q.regs[REG_FREQ]) begin
        core_d.fdiv = 8'h00;
        core_d.fout = ~core_q.fout;
      end else begin
        core_d.fdiv = 8'(core_q.fdiv + 8'h01);
      end
    end
    if (tick) begin
      core_d.regs[REG_SEC] = 8'(core_q.regs[REG_SEC] + 8'h01); // R09
      if (core_q.regs[REG_SEC] == 8'h3B) begin
        core_d.regs[REG_SEC] = 8'h00;
        core_d.regs[REG_MIN] = 8'(core_q.regs[REG_MIN] + 8'h01);
        if (core_q.regs[REG_MIN] == 8'h3B) begin
          core_d.regs[REG_MIN]  = 8'h00;
          core_d.regs[REG_HOUR] = 8'(core_q.regs[REG_HOUR] + 8'h01);
          if (core_q.regs[REG_HOUR] == 8'h17) begin
            core_d.regs[REG_HOUR] = 8'h00;
            core_d.regs[REG_DAY]  = 8'(core_q.regs[REG_DAY] + 8'h01);
            if (core_q.regs[REG_DAY] >=
                days_in_month(core_q.regs[REG_MONTH], core_q.regs[REG_YEAR])) begin // R09
              core_d.regs[REG_DAY]   = 8'h01;
              core_d.regs[REG_MONTH] = 8'(core_q.regs[REG_MONTH] + 8'h01);
              if (core_q.regs[REG_MONTH] >= 8'h0C) begin
                core_d.regs[REG_MONTH] = 8'h01;
                core_d.regs[REG_YEAR]  = (core_q.regs[REG_YEAR] >= 8'h63) ? 8'h00 :
                                         8'(core_q.regs[REG_YEAR] + 8'h01);
              end
            end
          end
        end
      end
    end else if (pop_fire && (pop_if.data[11:8] < 4'(NUM_REGS))) begin
      if (pop_if.data[11:8] == REG_STAT1) begin
        core_d.regs[REG_STAT1] = core_q.regs[REG_STAT1] & ~pop_if.data[7:0] & ST1_MASK;
      end else begin
        core_d.regs[pop_if.data[11:8]] = pop_if.data[7:0];
      end
    end
    // A low-supply event in the cycle of a clearing write still sets the flag.
    if (core_q.lv_s2) begin
      core_d.regs[REG_STAT1][ST1_LOWV] = 1'b1; // R10
    end
    if (!core_q.cs_s2) begin
      core_d.snap = core_d.regs;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      core_q <= CORE_RST; // R10
    end else begin
      core_q <= core_d;
    end
  end

  assign O_INT_N_O  = 1'b0;
  assign O_INT_N_OE = core_q.int_oe; // R08

  // ****************************************************************
  // Assertions
  // ****************************************************************
  cs_quiet_a: assert property (@(posedge I_SCK) disable iff (!I_RSTN) // R03
    !I_CS |-> (lk_q.phase == LK_CMD) && (lk_q.cnt == 4'h0))
    else $error("link state moved while chip select low");
  cs_float_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R02
    !I_CS |-> (lk_q.phase == LK_CMD) && !lk_q.drv_low)
    else $error("low chip select did not hold frame idle");
  sio_release_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R05
    !I_CS |-> !O_SIO_OE && !O_SIO_O)
    else $error("data pin driven with chip select low");
  cmd_input_a: assert property (@(posedge I_SCK) disable iff (!lk_rst_n) // R06
    (lk_q.phase == LK_CMD) |-> !O_SIO_OE)
    else $error("data pin driven during command phase");
  read_shift_a: assert property (@(posedge I_SCK) disable iff (!lk_rst_n) // R04
    (lk_q.phase == LK_RD && lk_q.cnt != LAST_BIT) |=> (O_SIO_OE == !$past(lk_q.out_sh[7])))
    else $error("read bit not shifted out");
  write_word_a: assert property (@(posedge I_SCK) disable iff (!lk_rst_n) // R04 R01
    (lk_q.phase == LK_WR && lk_q.cnt == LAST_BIT) |=>
      (wp_q.tgl != $past(wp_q.tgl)) && (wp_q.word[11:8] == $past(lk_q.addr)))
    else $error("write word not posted at frame end");
  int_route_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R07
    (src == SRC_PER2) |=> O_INT_N_OE == ($past(core_q.regs[REG_SEC]) == 8'h00))
    else $error("interrupt source not routed");
  int_off_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R08
    (core_q.regs[REG_STAT2][2:0] > 3'h5) |=> !O_INT_N_OE && !O_INT_N_O)
    else $error("interrupt pin driven with no source");
  min_roll_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R09
    (tick && core_q.regs[REG_SEC] == 8'h3B && core_q.regs[REG_MIN] != 8'h3B) |=>
      (core_q.regs[REG_SEC] == 8'h00) && (core_q.regs[REG_MIN] == $past(core_q.regs[REG_MIN]) + 8'h01))
    else $error("minute did not roll over");
  leap_day_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R09
    (tick && core_q.regs[REG_MONTH] == 8'h02 && core_q.regs[REG_DAY] == 8'h1C &&
     core_q.regs[REG_HOUR] == 8'h17 && core_q.regs[REG_MIN] == 8'h3B &&
     core_q.regs[REG_SEC] == 8'h3B) |=>
      (core_q.regs[REG_DAY] == ((core_q.regs[REG_YEAR][1:0] == 2'h0) ? 8'h1D : 8'h01)))
    else $error("leap day handled wrongly");
  low_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R10
    core_q.lv_s2 |=> core_q.regs[REG_STAT1][ST1_LOWV])
    else $error("low supply flag not set");
  tgl_quiet_a: assert property (@(posedge I_SCK) disable iff (!I_RSTN) // R03
    !I_CS |=> $stable(wp_q.tgl))
    else $error("write word posted with chip select low");
  snap_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R04
    core_q.cs_s2 |=> $stable(core_q.snap))
    else $error("read snapshot moved during a frame");
  int_clk_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R07
    (src == SRC_32K) |=> O_INT_N_OE == $past(core_q.clk32))
    else $error("clock source not routed");
  word_take_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R04
    (core_q.tg_s2 != core_q.tg_s3) |=> core_q.pend && (core_q.pend_word == $past(wp_q.word)))
    else $error("posted write word not taken");

  write_frame_c: cover property (@(posedge I_SCK) disable iff (!lk_rst_n)
    lk_q.phase == LK_WR && lk_q.cnt == LAST_BIT);
  read_frame_c: cover property (@(posedge I_SCK) disable iff (!lk_rst_n)
    lk_q.phase == LK_RD && lk_q.cnt == LAST_BIT);
  reg_write_c: cover property (@(posedge I_CLK) disable iff (!I_RSTN) pop_fire);
  day_roll_c: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
    tick && core_q.regs[REG_HOUR] == 8'h17 && core_q.regs[REG_MIN] == 8'h3B &&
    core_q.regs[REG_SEC] == 8'h3B);

endmodule : rtcp_top
`default_nettype wire

// ---- bench/rtcp_host_model.sv ----
// Host model that drives frames and stray clocks on the three-wire link.
`timescale 1ns/1ps
`default_nettype none
module rtcp_host_model (
  output logic      o_cs,
  output logic      o_sck,
  output logic      o_sio_en,
  output logic      o_sio_bit,
  input  wire logic i_sio_wire
);
  // ****************************************************************
  // Link driver
  // ****************************************************************
  initial begin
    o_cs      = 1'b0;
    o_sck     = 1'b0;
    o_sio_en  = 1'b0;
    o_sio_bit = 1'b0;
  end

  // One command byte then one data byte; on a read the data pin is let go.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] frame;
    frame = {cmd, wd};
    rd    = 8'h00;
    o_cs  = 1'b1;
    #100;
    for (int k = 0; k < 16; k++) begin
      o_sio_en  = (k < 8) || !cmd[0];
      o_sio_bit = frame[15-k];
      #16 o_sck = 1'b1;
      #16;
      if (k >= 7 && k < 15) begin
        rd[14-k] = i_sio_wire;
      end
      o_sck = 1'b0;
    end
    o_sio_en = 1'b0;
    #16 o_cs = 1'b0;
    #300;
  endtask : xfer

  // Clocks a whole frame pattern with chip select low and counts pulled bits.
  task automatic stray(input logic [15:0] pat, output logic [7:0] bad);
    bad = 8'h00;
    for (int k = 0; k < 16; k++) begin
      o_sio_en  = 1'b1;
      o_sio_bit = pat[15-k];
      #16 o_sck = 1'b1;
      #16 o_sck = 1'b0;
      if (i_sio_wire !== o_sio_bit) begin
        bad++;
      end
    end
    o_sio_en = 1'b0;
    #300;
  endtask : stray
endmodule : rtcp_host_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the three-wire clock host port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtcp_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       low_vdd;
  logic       cs;
  logic       sck;
  logic       h_en;
  logic       h_bit;
  logic       sio_o;
  logic       sio_oe;
  logic       int_o;
  logic       int_oe;
  wire logic  sio_wire;
  int         fails;
  int         checks;
  logic [7:0] r;

  // Open-drain data line with pull-up.
  assign sio_wire = sio_oe ? 1'b0 : (h_en ? h_bit : 1'b1);

  rtcp_top #(.CLK_HZ(131072), .HALF_SEC(8)) dut (
    .I_CLK(clk), .I_RSTN(rst_n), .I_SCK(sck), .I_CS(cs),
    .I_SIO_I(sio_wire), .I_LOW_VDD(low_vdd), .O_SIO_O(sio_o),
    .O_SIO_OE(sio_oe), .O_INT_N_O(int_o), .O_INT_N_OE(int_oe)
  );

  rtcp_host_model host (
    .o_cs(cs), .o_sck(sck), .o_sio_en(h_en), .o_sio_bit(h_bit), .i_sio_wire(sio_wire)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    host.xfer({CMD_CODE, a, 1'b0}, d, dummy);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    host.xfer({CMD_CODE, a, 1'b1}, 8'hFF, r);
  endtask : rd

  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(REG_STAT1);
    chk("stat1", 8'h01, r);
    rd(REG_STAT2);
    chk("stat2", 8'h07, r);
    rd(REG_MONTH);
    chk("month", 8'h01, r);
    $display("reset values done");
  endtask : t_reset

  // A complete write frame clocked with chip select low must change nothing.
  task automatic t_ignore;
    logic [7:0] bad;
    host.stray({CMD_CODE, REG_ALM1, 1'b0, 8'h5A}, bad);
    chk("pin pulled", 8'h00, bad);
    rd(REG_ALM1);
    chk("alm1", 8'h00, r);
    $display("ignore done");
  endtask : t_ignore

  task automatic t_wrrd;
    wr(REG_ALM1, 8'h5A);
    rd(REG_ALM1);
    chk("alm1", 8'h5A, r);
    chk("sio release", 8'h00, {7'h00, sio_oe});
    chk("sio level", 8'h00, {7'h00, sio_o});
    host.xfer({3'h0, REG_ALM1, 1'b0}, 8'hA5, r);
    rd(REG_ALM1);
    chk("alm1 bad code", 8'h5A, r);
    wr(4'hC, 8'h77);
    rd(4'hC);
    chk("unmapped", 8'h00, r);
    $display("write read done");
  endtask : t_wrrd

  task automatic t_flags;
    wr(REG_STAT1, 8'h03);
    rd(REG_STAT1);
    chk("stat1 clear", 8'h00, r);
    @(negedge clk);
    low_vdd = 1'b1;
    repeat (5) @(negedge clk);
    low_vdd = 1'b0;
    rd(REG_STAT1);
    chk("stat1 lowv", 8'h02, r);
    $display("flags done");
  endtask : t_flags

  // Feb 28 23:59:59 of the given year, read back about three seconds later.
  task automatic t_cal(input logic [7:0] y, input logic [7:0] nd, input logic [7:0] nm);
    wr(REG_SEC, 8'h00);
    wr(REG_YEAR, y);
    wr(REG_MONTH, 8'h02);
    wr(REG_DAY, 8'h1C);
    wr(REG_HOUR, 8'h17);
    wr(REG_MIN, 8'h3B);
    wr(REG_SEC, 8'h3B);
    repeat (40) @(posedge clk);
    rd(REG_DAY);
    chk("day", nd, r);
    rd(REG_MONTH);
    chk("month", nm, r);
    $display("calendar year %0d done", y);
  endtask : t_cal

  task automatic t_int;
    int hi;
    int bad;
    wr(REG_SEC, 8'h00);
    wr(REG_MIN, 8'h00);
    wr(REG_HOUR, 8'h00);
    wr(REG_ALM1, 8'h00);
    wr(REG_ALM2, 8'h00);
    wr(REG_FREQ, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(REG_STAT2, 8'(s));
      hi  = 0;
      bad = 0;
      repeat (1000) begin
        @(negedge clk);
        if (int_oe === 1'b1) begin
          hi++;
        end
        if (int_o !== 1'b0) begin
          bad++;
        end
      end
      chk("int seen", (s < 6) ? 8'h01 : 8'h00, (hi > 0) ? 8'h01 : 8'h00);
      chk("int drive high", 8'h00, 8'(bad));
    end
    $display("interrupt sources done");
  endtask : t_int

  initial begin
    fails   = 0;
    checks  = 0;
    low_vdd = 1'b0;
    rst_n   = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    t_reset;
    t_ignore;
    t_wrrd;
    t_flags;
    t_cal(8'h04, 8'h1D, 8'h02);
    t_cal(8'h00, 8'h1D, 8'h02);
    t_cal(8'h63, 8'h01, 8'h03);
    t_int;
    tally_and_finish;
  end

  // Cuts a hang short.
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
